// >>> prcn_defines.svh
// Register map, field positions and reset values of the pin remap block
`ifndef PRCN_DEFINES_SVH
`define PRCN_DEFINES_SVH

`define PRCN_NUM_IN      4
`define PRCN_NUM_OUT     4
`define PRCN_NUM_PORT    3
`define PRCN_SEL_W       4
`define PRCN_ADDR_W      8
`define PRCN_CFG_ADDR    8'h00
`define PRCN_IN_BASE     8'h10
`define PRCN_OUT_BASE    8'h20
`define PRCN_NOTE_BASE   8'h30
`define PRCN_IDLE_ADDR   8'h40
`define PRCN_LOCK_BIT    13
`define PRCN_NOTE_EN_BIT   15
`define PRCN_NOTE_STOP_BIT 13
`define PRCN_SEL_RST     4'h0
`define PRCN_HTRANS_NSEQ 2'h2
`define PRCN_HSIZE_WORD  3'h2

`endif

// >>> prcn_pkg.sv
// Types shared by the pin remap and change notice block
`default_nettype none
package prcn_pkg;
	typedef logic [3:0] prcn_sel_type;
endpackage
`default_nettype wire

// >>> prcn_cn_port.sv
// Change notice control for one port
`timescale 1ns/1ps
`default_nettype none
`include "prcn_defines.svh"
module prcn_notice_port
	import prcn_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        idle_i,
	output var  logic        on_o,
	output var  logic        stop_o,
	output var  logic        active_o
);
	logic on_d;
	logic stop_d;
	logic act_d;

	always_comb begin
		on_d   = on_o;
		stop_d = stop_o;
		if (wr_i) begin
			on_d   = wdata_i[`PRCN_NOTE_EN_BIT];
			stop_d = wdata_i[`PRCN_NOTE_STOP_BIT];
		end
		act_d = on_d && !(stop_d && idle_i);
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			on_o     <= 1'b0;
			stop_o   <= 1'b0;
			active_o <= 1'b0;
		end else begin
			on_o     <= on_d;
			stop_o   <= stop_d;
			active_o <= act_d;
		end
	end
endmodule
`default_nettype wire

// >>> prcn_top.sv
// Pin remap select registers and change notice control on AHB-Lite
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "prcn_defines.svh"
module prcn_top
	import prcn_pkg::*;
(
	input  wire logic        CLOCK_I,
	input  wire logic        RESET_I,
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	input  wire logic        IDLE_I,
	output var  logic [31:0] HRDATA_O,
	output var  logic        HREADYOUT_O,
	output var  logic        HRESP_O,
	output var  logic [15:0] IN_SEL_O,
	output var  logic [15:0] OUT_SEL_O,
	output var  logic [2:0]  NOTE_ACTIVE_O,
	output var  logic        LOCK_O
);
	prcn_sel_type in_q  [`PRCN_NUM_IN];
	prcn_sel_type in_d  [`PRCN_NUM_IN];
	prcn_sel_type out_q [`PRCN_NUM_OUT];
	prcn_sel_type out_d [`PRCN_NUM_OUT];
	logic                    lock_d;
	logic                    wr_pend_q;
	logic                    wr_pend_d;
	logic                    rd_pend_q;
	logic                    rd_pend_d;
	logic [`PRCN_ADDR_W-1:0] addr_q;
	logic [`PRCN_ADDR_W-1:0] addr_d;
	logic [31:0]             rdata_d;
	logic [2:0]              note_wr;
	logic [2:0]              note_on;
	logic [2:0]              note_stop;
	logic                    take;

	assign take = HSEL_I && HREADY_I && (HTRANS_I == `PRCN_HTRANS_NSEQ);

	// Address phase capture; slave is zero wait state
	always_comb begin
		wr_pend_d = take && HWRITE_I;
		rd_pend_d = take && !HWRITE_I;
		addr_d    = take ? HADDR_I[`PRCN_ADDR_W-1:0] : addr_q;
	end

	// Select writes: locked writes simply keep the old code
	always_comb begin
		lock_d = LOCK_O;
		if (wr_pend_q && addr_q == `PRCN_CFG_ADDR)
			lock_d = HWDATA_I[`PRCN_LOCK_BIT];
		for (int i = 0; i < `PRCN_NUM_IN; i++) begin
			in_d[i] = in_q[i];
			if (wr_pend_q && !LOCK_O &&
			    addr_q == `PRCN_IN_BASE + 8'(4*i))
				in_d[i] = HWDATA_I[`PRCN_SEL_W-1:0];
		end
		for (int i = 0; i < `PRCN_NUM_OUT; i++) begin
			out_d[i] = out_q[i];
			if (wr_pend_q && !LOCK_O &&
			    addr_q == `PRCN_OUT_BASE + 8'(4*i))
				out_d[i] = HWDATA_I[`PRCN_SEL_W-1:0];
		end
	end

	genvar p;
	generate
		for (p = 0; p < `PRCN_NUM_PORT; p++) begin : g_note
			assign note_wr[p] = wr_pend_q &&
				addr_q == `PRCN_NOTE_BASE + 8'(4*p);
			prcn_notice_port u_prcn_notice_port (
				.clk_i    (CLOCK_I),
				.rst_i    (RESET_I),
				.wr_i     (note_wr[p]),
				.wdata_i  (HWDATA_I),
				.idle_i   (IDLE_I),
				.on_o     (note_on[p]),
				.stop_o   (note_stop[p]),
				.active_o (NOTE_ACTIVE_O[p])
			);
		end
	endgenerate

	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata_d = 32'h0;
		if (rd_pend_d) begin
			if (HADDR_I[`PRCN_ADDR_W-1:0] == `PRCN_CFG_ADDR)
				rdata_d[`PRCN_LOCK_BIT] = LOCK_O;
			if (HADDR_I[`PRCN_ADDR_W-1:0] == `PRCN_IDLE_ADDR)
				rdata_d[0] = IDLE_I;
			for (int i = 0; i < `PRCN_NUM_IN; i++)
				if (HADDR_I[`PRCN_ADDR_W-1:0] == `PRCN_IN_BASE + 8'(4*i))
					rdata_d[`PRCN_SEL_W-1:0] = in_d[i];
			for (int i = 0; i < `PRCN_NUM_OUT; i++)
				if (HADDR_I[`PRCN_ADDR_W-1:0] == `PRCN_OUT_BASE + 8'(4*i))
					rdata_d[`PRCN_SEL_W-1:0] = out_d[i];
			for (int i = 0; i < `PRCN_NUM_PORT; i++)
				if (HADDR_I[`PRCN_ADDR_W-1:0] == `PRCN_NOTE_BASE + 8'(4*i)) begin
					rdata_d[`PRCN_NOTE_EN_BIT]   = note_on[i];
					rdata_d[`PRCN_NOTE_STOP_BIT] = note_stop[i];
				end
		end
	end

	always_ff @(posedge CLOCK_I or posedge RESET_I) begin
		if (RESET_I) begin
			for (int i = 0; i < `PRCN_NUM_IN; i++)
				in_q[i] <= `PRCN_SEL_RST;
			for (int i = 0; i < `PRCN_NUM_OUT; i++)
				out_q[i] <= `PRCN_SEL_RST;
			LOCK_O      <= 1'b0;
			wr_pend_q   <= 1'b0;
			rd_pend_q   <= 1'b0;
			addr_q      <= '0;
			HRDATA_O    <= 32'h0;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
			IN_SEL_O    <= 16'h0;
			OUT_SEL_O   <= 16'h0;
		end else begin
			for (int i = 0; i < `PRCN_NUM_IN; i++)
				in_q[i] <= in_d[i];
			for (int i = 0; i < `PRCN_NUM_OUT; i++)
				out_q[i] <= out_d[i];
			LOCK_O      <= lock_d;
			wr_pend_q   <= wr_pend_d;
			rd_pend_q   <= rd_pend_d;
			addr_q      <= addr_d;
			HRDATA_O    <= rdata_d;
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
			IN_SEL_O    <= {in_d[3], in_d[2], in_d[1], in_d[0]};
			OUT_SEL_O   <= {out_d[3], out_d[2], out_d[1], out_d[0]};
		end
	end

	AST_LOCKED_HOLD: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		LOCK_O |=> $stable(in_q[0]) && $stable(out_q[0]))
		else $error("Select changed while locked");
	AST_UNLOCKED_WRITE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		wr_pend_q && !LOCK_O && addr_q == `PRCN_OUT_BASE |=>
		out_q[0] == $past(HWDATA_I[3:0]))
		else $error("Unlocked select write lost");
	AST_IN_WRITE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		wr_pend_q && !LOCK_O && addr_q == `PRCN_IN_BASE |=>
		in_q[0] == $past(HWDATA_I[3:0]))
		else $error("Input select write lost");
	AST_OUT_PIN: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		OUT_SEL_O[3:0] == out_q[0])
		else $error("Output select mismatch");
	AST_SEL_READ_ZERO: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		rd_pend_q && addr_q >= `PRCN_IN_BASE && addr_q < `PRCN_NOTE_BASE |->
		HRDATA_O[31:4] == 28'h0)
		else $error("Select upper bits not zero");
	AST_NOTE_READ_ZERO: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		rd_pend_q && addr_q >= `PRCN_NOTE_BASE && addr_q < `PRCN_IDLE_ADDR |->
		HRDATA_O[31:16] == 16'h0 && HRDATA_O[14] == 1'b0 && HRDATA_O[12:0] == 13'h0)
		else $error("Change notice reserved bits not zero");
	AST_NOTE_ENABLE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		note_wr[1] |=> note_on[1] == $past(HWDATA_I[15]) && $stable(note_on[0]))
		else $error("Change notice enable wrong");
	// A write in the same cycle may clear the stop bit, so it is excluded
	AST_NOTE_IDLE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		note_stop[0] && IDLE_I && !note_wr[0] |=> !NOTE_ACTIVE_O[0])
		else $error("Change notice not halted in idle");

	AST_IN_LOCKED_KEEP: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		wr_pend_q && LOCK_O && addr_q == `PRCN_IN_BASE |=> $stable(in_q[0]))
		else $error("Locked input select changed");

	AST_OUT_LOCKED_KEEP: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		wr_pend_q && LOCK_O && addr_q == `PRCN_OUT_BASE |=> $stable(out_q[0]))
		else $error("Locked output select changed");

	AST_IN_PIN: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		IN_SEL_O[3:0] == in_q[0])
		else $error("Input select mismatch");

	AST_NOTE_OFF: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		!note_on[0] && !note_wr[0] |=> !NOTE_ACTIVE_O[0])
		else $error("Change notice active while off");

	AST_NOTE_RUN: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		note_on[0] && !note_wr[0] && !(note_stop[0] && IDLE_I) |=>
		NOTE_ACTIVE_O[0])
		else $error("Change notice halted wrongly");

	AST_NOTE_PORT_ALONE: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		note_wr[0] |=> $stable(note_on[1]) && $stable(note_stop[1]))
		else $error("Change notice write touched another port");

	AST_LOCK_READ: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
		rd_pend_q && addr_q == `PRCN_CFG_ADDR |->
		HRDATA_O[`PRCN_LOCK_BIT] == $past(LOCK_O))
		else $error("Lock bit read wrong");
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking testbench for the pin remap and change notice block
`timescale 1ns/1ps
`default_nettype none
`include "prcn_defines.svh"
module testbench
	import prcn_pkg::*;
;
	logic        clk, rst, hsel, hwrite, hready, hresp, idle, lock;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0]  htrans;
	logic [2:0]  hsize, note_act, en_m, sl_m;
	logic [15:0] in_sel, out_sel;
	int          n_fail, n_checks;

	prcn_top u_prcn_top (.CLOCK_I(clk), .RESET_I(rst), .HSEL_I(hsel),
		.HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
		.HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
		.IDLE_I(idle), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
		.HRESP_O(hresp), .IN_SEL_O(in_sel), .OUT_SEL_O(out_sel),
		.NOTE_ACTIVE_O(note_act), .LOCK_O(lock));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Address phase held until hready, then data phase held until hready
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= `PRCN_HTRANS_NSEQ;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rv = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rv, exp);
		chk({31'h0, hresp}, 32'h0);
	endtask

	// Outputs are registered one cycle behind, so let two edges pass
	task automatic act_chk;
		repeat (2) @(posedge clk);
		chk({29'h0, note_act}, {29'h0, en_m & ~(sl_m & {3{idle}})});
	endtask

	task automatic t_reset;
		for (int i = 0; i < 4; i++) begin
			rd(`PRCN_IN_BASE + 8'(4 * i), 32'h0);
			rd(`PRCN_OUT_BASE + 8'(4 * i), 32'h0);
		end
		for (int p = 0; p < 3; p++)
			rd(`PRCN_NOTE_BASE + 8'(4 * p), 32'h0);
		chk({in_sel, out_sel}, 32'h0);
	endtask

	// Upper bits are written nonzero to prove they read back zero
	task automatic t_select;
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `PRCN_IN_BASE + 8'(4 * i), 32'hdead_bee0 | 32'(12 + i));
			rd(`PRCN_IN_BASE + 8'(4 * i), 32'(12 + i));
			chk({28'h0, in_sel[4*i+:4]}, 32'(12 + i));
			xfer(1'b1, `PRCN_OUT_BASE + 8'(4 * i), 32'hffff_fff0 | 32'(3 * i + 1));
			rd(`PRCN_OUT_BASE + 8'(4 * i), 32'(3 * i + 1));
			chk({28'h0, out_sel[4*i+:4]}, 32'(3 * i + 1));
		end
	endtask

	task automatic t_lock;
		xfer(1'b1, `PRCN_CFG_ADDR, 32'h2000);
		rd(`PRCN_CFG_ADDR, 32'h2000);
		chk({31'h0, lock}, 32'h1);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b1, `PRCN_IN_BASE + 8'(4 * i), 32'h5);
			xfer(1'b1, `PRCN_OUT_BASE + 8'(4 * i), 32'h6);
			rd(`PRCN_IN_BASE + 8'(4 * i), 32'(12 + i));
			rd(`PRCN_OUT_BASE + 8'(4 * i), 32'(3 * i + 1));
		end
		chk({in_sel, out_sel}, 32'hfedc_a741);
		xfer(1'b1, `PRCN_CFG_ADDR, 32'h0);
		xfer(1'b1, `PRCN_IN_BASE, 32'h5);
		rd(`PRCN_IN_BASE, 32'h5);
	endtask

	task automatic t_note;
		for (int p = 0; p < 3; p++) begin
			xfer(1'b1, `PRCN_NOTE_BASE + 8'(4 * p), 32'hffff_ffff);
			rd(`PRCN_NOTE_BASE + 8'(4 * p), 32'h0000_a000);
			en_m[p] = 1'b1;
			sl_m[p] = 1'b1;
			act_chk;
			idle <= 1'b1;
			act_chk;
			rd(`PRCN_IDLE_ADDR, 32'h1);
			xfer(1'b1, `PRCN_NOTE_BASE + 8'(4 * p), 32'h8000);
			sl_m[p] = 1'b0;
			act_chk;
			idle <= 1'b0;
		end
		for (int p = 0; p < 3; p++) begin
			xfer(1'b1, `PRCN_NOTE_BASE + 8'(4 * p), 32'h0);
			en_m[p] = 1'b0;
			act_chk;
		end
	endtask

	initial begin
		{hsel, hwrite, idle, haddr, hwdata, htrans} = '0;
		{en_m, sl_m, n_fail, n_checks} = '0;
		hsize = `PRCN_HSIZE_WORD;
		rst = 1'b1;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset;
		t_select;
		t_lock;
		t_note;
		final_report;
	end

	// A run needs under two hundred cycles; far beyond that means a hang
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		final_report;
	end
endmodule
`default_nettype wire
